//--- logic/touch_key_pkg.sv
`default_nettype none
package touch_key_pkg;

  // ==========================================================
  // register byte offsets
  localparam logic [7:0] OFS_SLOT_PRELOAD = 8'h00;
  localparam logic [7:0] OFS_SENSE_CONTROL_A = 8'h04;
  localparam logic [7:0] OFS_SENSE_CONTROL_B = 8'h08;
  localparam logic [7:0] OFS_CALIB_COUNT_LOW = 8'h0c;
  localparam logic [7:0] OFS_CALIB_COUNT_HIGH = 8'h10;
  localparam logic [7:0] OFS_PAD_COUNT_LOW = 8'h14;
  localparam logic [7:0] OFS_PAD_COUNT_HIGH = 8'h18;
  localparam logic [7:0] OFS_REF_CAPACITOR_LOW = 8'h1c;
  localparam logic [7:0] OFS_REF_CAPACITOR_HIGH = 8'h20;
  localparam logic [7:0] OFS_MODULE_CONTROL_A = 8'h24;
  localparam logic [7:0] OFS_MODULE_CONTROL_B = 8'h28;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h2c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h30;

  // ==========================================================
  // sense_control_a fields
  localparam int BIT_WINDOW_OVF = 6;
  localparam int BIT_DETECTION_START = 5;
  localparam int BIT_PAD_COUNT_OVF = 4;
  localparam int BIT_CALIB_COUNT_OVF = 3;
  localparam int BIT_CALIB_SEL_LO = 0;
  // module_control_a fields
  localparam int BIT_PAD_MUX_LO = 6;
  // module_control_b fields
  localparam int BIT_SLOT_CLOCK_SELECT = 7;
  localparam int BIT_REF_OSC_ENABLE = 5;
  localparam int BIT_PAD_OSC_ENABLE = 4;
  localparam int BIT_SECOND_PAD_ENABLE = 1;
  localparam int BIT_FIRST_PAD_ENABLE = 0;
  localparam logic [7:0] MODULE_CONTROL_B_MASK = 8'hb3;
  // irq status / mask bits
  localparam int IRQ_WINDOW_END = 0;
  localparam int IRQ_PAD_OVF = 1;
  localparam int IRQ_CALIB_OVF = 2;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_SLOT_PRELOAD = 8'h00;
  localparam logic [1:0] RST_CALIB_SEL = 2'h0;
  localparam logic [1:0] RST_FREQ_SEL = 2'h3;
  localparam logic [9:0] RST_REF_CAPACITOR = 10'h000;
  localparam logic [7:0] RST_MODULE_CONTROL = 8'h00;
  localparam logic [2:0] RST_IRQ_MASK = 3'h0;

  // ==========================================================
  // timing: system clock divided by 4 for the slot clock
  localparam logic [1:0] SLOT_SYS_DIV_LAST = 2'h3;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_DONE = 3'b100
  } sense_state_t;

endpackage
`default_nettype wire

//--- logic/capacitive_touch_key_counter.sv
// Overview of operation
// - slot counter starts at preload, overflows after 256 minus preload units.
// - 5-bit unit counter makes each slot increment 32 slot clock cycles.
// - slot overflow sets window and irq flags, stops oscillators and counters.
// - software writing 1 to window flag never raises the interrupt request.
// - start low clears pad, calib and unit counters, not the slot counter.
// - start rising switches on all counters and the oscillators together.
// - pad counter overflow sets its flag, held until software writes 0.
// - calib counter overflow sets its flag, held until software writes 0.
// - calib counter clocked from system clock divided by 1, 2, 4 or 8.
// - oscillator frequency field selects 1, 3, 7, 11 MHz, resets to 11.
// - calib count freezes at window end, cleared only by start low.
// - unimplemented control bits read zero and ignore writes.
// - two pads, each with own oscillator, share one control set.
// - slot clock is reference oscillator when 0, system clock over 4 when 1.
// - enables for reference oscillator, pad oscillator and each pad.
// - mux field 00 routes first pad, 01 second pad, others reserved.
// - pad count freezes at window end, cleared when start goes low.
//
// Decided for this implementation: the AHB-Lite register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module capacitive_touch_key_counter
  import touch_key_pkg::*;
#(
  parameter int UNIT_BITS = 5,
  parameter int SLOT_BITS = 8,
  parameter int COUNT_BITS = 16
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // oscillator outputs, sampled on hclk
  input wire logic first_sense_pad,
  input wire logic second_sense_pad,
  input wire logic ref_osc_in,
  // oscillator control
  output logic ref_osc_run,
  output logic first_pad_osc_run,
  output logic second_pad_osc_run,
  output logic [1:0] oscillator_frequency_select,
  output logic [9:0] ref_capacitor,
  output logic [5:0] pad_osc_tuning,
  // interrupt
  output logic irq
);

  // ==========================================================
  // state
  // one register set shared by both pads
  typedef struct packed {
    sense_state_t state;
    logic [7:0] preload;
    logic start;
    logic window_flag;
    logic pad_ovf_flag;
    logic calib_ovf_flag;
    logic [1:0] calib_sel;
    logic [1:0] freq_sel;
    logic [9:0] ref_cap;
    logic [7:0] mod_ctl_a;
    logic [7:0] mod_ctl_b;
    logic [UNIT_BITS-1:0] unit_cnt;
    logic [SLOT_BITS-1:0] slot_cnt;
    logic [COUNT_BITS-1:0] pad_cnt;
    logic [COUNT_BITS-1:0] calib_cnt;
    logic [2:0] calib_div;
    logic [1:0] sys_div;
    logic [2:0] irq_stat;
    logic [2:0] irq_mask;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    logic pad_prev;
    logic ref_prev;
  } ctl_t;

  ctl_t q;
  ctl_t d;

  logic addr_ok;
  logic [7:0] addr_lo;
  logic running;
  logic slot_tick;
  logic pad_sel;
  logic pad_edge;
  logic ref_edge;
  logic calib_tick;
  logic unit_wrap;
  logic window_end;
  logic pad_wrap;
  logic calib_wrap;
  logic [2:0] div_mask;
  logic [7:0] wb;
  logic [31:0] rmux;

  assign addr_lo = haddr[7:0];
  assign addr_ok = hsel & hready & htrans[1];
  assign running = (q.state == ST_RUN);

  // ==========================================================
  // sense sources
  always_comb
  begin
    // 00 first pad, 01 second pad, reserved codes route nothing
    case (q.mod_ctl_a[BIT_PAD_MUX_LO +: 2])
      2'h0: pad_sel = first_sense_pad & q.mod_ctl_b[BIT_FIRST_PAD_ENABLE];
      2'h1: pad_sel = second_sense_pad & q.mod_ctl_b[BIT_SECOND_PAD_ENABLE];
      default: pad_sel = 1'b0;
    endcase
  end

  // edge detectors reset low, the idle level of a stopped oscillator
  assign pad_edge = pad_sel & ~q.pad_prev & q.mod_ctl_b[BIT_PAD_OSC_ENABLE];
  assign ref_edge = ref_osc_in & ~q.ref_prev & q.mod_ctl_b[BIT_REF_OSC_ENABLE];

  // slot clock source; the reference source needs its enable set,
  // or no tick comes and the window never ends
  assign slot_tick = q.mod_ctl_b[BIT_SLOT_CLOCK_SELECT] ?
                     (q.sys_div == SLOT_SYS_DIV_LAST) : ref_edge;

  // calib prescaler: 1, 2, 4 or 8
  // held at zero in the idle state, so each window starts in phase
  always_comb
  begin
    case (q.calib_sel)
      2'h0: div_mask = 3'h0;
      2'h1: div_mask = 3'h1;
      2'h2: div_mask = 3'h3;
      default: div_mask = 3'h7;
    endcase
  end

  assign calib_tick = ((q.calib_div & div_mask) == div_mask);

  assign unit_wrap = slot_tick & (&q.unit_cnt);
  // window end leaves the run state, which stops every counter
  assign window_end = running & unit_wrap & (&q.slot_cnt);
  assign pad_wrap = running & pad_edge & (&q.pad_cnt);
  assign calib_wrap = running & calib_tick & (&q.calib_cnt);

  // ==========================================================
  // read mux; counts are live while running, so read each byte
  // pair in the done state, where it is frozen
  always_comb
  begin
    rmux = 32'h0000_0000;
    case (addr_lo)
      OFS_SLOT_PRELOAD: rmux[7:0] = q.preload;
      OFS_SENSE_CONTROL_A:
      begin
        rmux[BIT_WINDOW_OVF] = q.window_flag;
        rmux[BIT_DETECTION_START] = q.start;
        rmux[BIT_PAD_COUNT_OVF] = q.pad_ovf_flag;
        rmux[BIT_CALIB_COUNT_OVF] = q.calib_ovf_flag;
        rmux[BIT_CALIB_SEL_LO +: 2] = q.calib_sel;
      end
      OFS_SENSE_CONTROL_B: rmux[1:0] = q.freq_sel;
      OFS_CALIB_COUNT_LOW: rmux[7:0] = q.calib_cnt[7:0];
      OFS_CALIB_COUNT_HIGH: rmux[7:0] = q.calib_cnt[15:8];
      OFS_PAD_COUNT_LOW: rmux[7:0] = q.pad_cnt[7:0];
      OFS_PAD_COUNT_HIGH: rmux[7:0] = q.pad_cnt[15:8];
      OFS_REF_CAPACITOR_LOW: rmux[7:0] = q.ref_cap[7:0];
      OFS_REF_CAPACITOR_HIGH: rmux[1:0] = q.ref_cap[9:8];
      OFS_MODULE_CONTROL_A: rmux[7:0] = q.mod_ctl_a;
      OFS_MODULE_CONTROL_B: rmux[7:0] = q.mod_ctl_b;
      OFS_IRQ_STATUS: rmux[2:0] = q.irq_stat;
      OFS_IRQ_MASK: rmux[2:0] = q.irq_mask;
      default: rmux = 32'h0000_0000;
    endcase
  end

  // ==========================================================
  // next state
  always_comb
  begin
    d = q;
    wb = hwdata[7:0];
    d.pad_prev = pad_sel;
    d.ref_prev = ref_osc_in;
    d.sys_div = q.sys_div + 2'h1;

    // ahb address phase, zero wait states; a read whose address
    // phase meets a write's data phase to the same register gets
    // the old value, so one idle cycle between them is needed
    d.wr_pend = addr_ok & hwrite;
    if (addr_ok)
    begin
      d.wr_addr = addr_lo;
    end
    if (addr_ok & ~hwrite)
    begin
      d.rdata = rmux;
    end

    // ahb data phase writes
    if (q.wr_pend)
    begin
      case (q.wr_addr)
        OFS_SLOT_PRELOAD: d.preload = wb;
        OFS_SENSE_CONTROL_A:
        begin
          // stored as written; a written 1 does not touch irq status
          d.window_flag = wb[BIT_WINDOW_OVF];
          d.start = wb[BIT_DETECTION_START];
          d.pad_ovf_flag = wb[BIT_PAD_COUNT_OVF];
          d.calib_ovf_flag = wb[BIT_CALIB_COUNT_OVF];
          d.calib_sel = wb[BIT_CALIB_SEL_LO +: 2];
        end
        OFS_SENSE_CONTROL_B: d.freq_sel = wb[1:0];
        OFS_REF_CAPACITOR_LOW: d.ref_cap[7:0] = wb;
        OFS_REF_CAPACITOR_HIGH: d.ref_cap[9:8] = wb[1:0];
        OFS_MODULE_CONTROL_A: d.mod_ctl_a = wb;
        OFS_MODULE_CONTROL_B: d.mod_ctl_b = wb & MODULE_CONTROL_B_MASK;
        OFS_IRQ_STATUS: d.irq_stat = q.irq_stat & ~wb[2:0];
        OFS_IRQ_MASK: d.irq_mask = wb[2:0];
        default: d.irq_mask = d.irq_mask;
      endcase
    end

    // measurement sequence
    case (q.state)
      ST_IDLE:
      begin
        d.unit_cnt = '0;
        d.pad_cnt = '0;
        d.calib_cnt = '0;
        d.calib_div = 3'h0;
        if (q.start)
        begin
          d.state = ST_RUN;
          // slot counter loads the preload on the start edge
          d.slot_cnt = SLOT_BITS'(q.preload);
        end
      end
      ST_RUN:
      begin
        d.calib_div = q.calib_div + 3'h1;
        if (slot_tick)
        begin
          d.unit_cnt = q.unit_cnt + 1'b1;
        end
        if (unit_wrap)
        begin
          d.slot_cnt = q.slot_cnt + 1'b1;
        end
        if (pad_edge)
        begin
          d.pad_cnt = q.pad_cnt + 1'b1;
        end
        if (calib_tick)
        begin
          d.calib_cnt = q.calib_cnt + 1'b1;
        end
        if (window_end)
        begin
          d.state = ST_DONE;
        end
        if (~q.start)
        begin
          d.state = ST_IDLE;
        end
      end
      ST_DONE:
      begin
        // counts held for readout
        if (~q.start)
        begin
          d.state = ST_IDLE;
        end
      end
      default: d.state = ST_IDLE;
    endcase

    // start low holds the counters cleared from the edge its
    // write lands; the slot counter keeps its value
    if (~d.start)
    begin
      d.state = ST_IDLE;
      d.unit_cnt = '0;
      d.pad_cnt = '0;
      d.calib_cnt = '0;
      d.calib_div = 3'h0;
    end

    // hardware sets win over software clears
    if (window_end)
    begin
      d.window_flag = 1'b1;
      d.irq_stat[IRQ_WINDOW_END] = 1'b1;
    end
    if (pad_wrap)
    begin
      d.pad_ovf_flag = 1'b1;
      d.irq_stat[IRQ_PAD_OVF] = 1'b1;
    end
    if (calib_wrap)
    begin
      d.calib_ovf_flag = 1'b1;
      d.irq_stat[IRQ_CALIB_OVF] = 1'b1;
    end
  end

  // ==========================================================
  // registers
  // every field has a constant reset value
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      q.state <= ST_IDLE;
      q.preload <= RST_SLOT_PRELOAD;
      q.start <= 1'b0;
      q.window_flag <= 1'b0;
      q.pad_ovf_flag <= 1'b0;
      q.calib_ovf_flag <= 1'b0;
      q.calib_sel <= RST_CALIB_SEL;
      q.freq_sel <= RST_FREQ_SEL;
      q.ref_cap <= RST_REF_CAPACITOR;
      q.mod_ctl_a <= RST_MODULE_CONTROL;
      q.mod_ctl_b <= RST_MODULE_CONTROL;
      q.unit_cnt <= '0;
      q.slot_cnt <= '0;
      q.pad_cnt <= '0;
      q.calib_cnt <= '0;
      q.calib_div <= 3'h0;
      q.sys_div <= 2'h0;
      q.irq_stat <= 3'h0;
      q.irq_mask <= RST_IRQ_MASK;
      q.wr_pend <= 1'b0;
      q.wr_addr <= 8'h00;
      q.rdata <= 32'h0000_0000;
      q.pad_prev <= 1'b0;
      q.ref_prev <= 1'b0;
    end
    else
    begin
      q <= d;
    end
  end

  // ==========================================================
  // outputs
  // zero wait states, always an okay response
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = q.rdata;

  // oscillators run only inside the window
  assign ref_osc_run = running & q.mod_ctl_b[BIT_REF_OSC_ENABLE];
  assign first_pad_osc_run = running & q.mod_ctl_b[BIT_PAD_OSC_ENABLE] &
                             q.mod_ctl_b[BIT_FIRST_PAD_ENABLE];
  assign second_pad_osc_run = running & q.mod_ctl_b[BIT_PAD_OSC_ENABLE] &
                              q.mod_ctl_b[BIT_SECOND_PAD_ENABLE];
  assign oscillator_frequency_select = q.freq_sel;
  assign ref_capacitor = q.ref_cap;
  assign pad_osc_tuning = q.mod_ctl_a[5:0];
  // level request while an unmasked status bit is set
  assign irq = |(q.irq_stat & q.irq_mask);

endmodule
`default_nettype wire

//--- testbench/touch_key_props.sv
`timescale 1ns/1ns
`default_nettype none
module touch_key_props
  import touch_key_pkg::*;
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // block outputs
  input wire logic ref_osc_run,
  input wire logic first_pad_osc_run,
  input wire logic [1:0] oscillator_frequency_select,
  input wire logic irq
);
  // ==========
  // write data phase tracking
  logic take;
  logic wr_q;
  logic [7:0] addr_q;
  assign take = hsel && hready && htrans[1];
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
    begin
      wr_q <= 1'b0;
      addr_q <= 8'h00;
    end
    else
    begin
      wr_q <= take && hwrite;
      addr_q <= haddr[7:0];
    end
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  property p_rdata_hold;
    $changed(hrdata) |-> $past(take && !hwrite);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold)
    else $error("read data moved without a read");
  property p_ctrlb_zero;
    take && !hwrite && haddr[7:0] == OFS_SENSE_CONTROL_B |=> hrdata[31:2] == 0;
  endproperty
  a_ctrlb_zero: assert property (p_ctrlb_zero)
    else $error("unimplemented bits read nonzero");
  property p_freq_write;
    wr_q && addr_q == OFS_SENSE_CONTROL_B
      |=> oscillator_frequency_select == $past(hwdata[1:0]);
  endproperty
  a_freq_write: assert property (p_freq_write)
    else $error("frequency select not written");
  property p_freq_hold;
    $changed(oscillator_frequency_select) |-> $past(wr_q);
  endproperty
  a_freq_hold: assert property (p_freq_hold)
    else $error("frequency select changed alone");
  property p_irq_fall;
    $fell(irq) |-> $past(wr_q);
  endproperty
  a_irq_fall: assert property (p_irq_fall)
    else $error("irq dropped without software");
  property p_ref_rise;
    $rose(ref_osc_run) |-> $past(wr_q) || $past(wr_q, 2);
  endproperty
  a_ref_rise: assert property (p_ref_rise)
    else $error("reference oscillator started alone");
  property p_pad_rise;
    $rose(first_pad_osc_run) |-> $past(wr_q) || $past(wr_q, 2);
  endproperty
  a_pad_rise: assert property (p_pad_rise)
    else $error("pad oscillator started alone");
  property p_stop_all;
    $fell(ref_osc_run) && !$past(wr_q) |-> !first_pad_osc_run;
  endproperty
  a_stop_all: assert property (p_stop_all)
    else $error("pad oscillator kept running at window end");
  c_window: cover property ($fell(ref_osc_run) && !$past(wr_q));
  c_irq: cover property ($rose(irq));
  c_freq: cover property ($changed(oscillator_frequency_select));
endmodule
bind capacitive_touch_key_counter touch_key_props touch_key_props_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .ref_osc_run(ref_osc_run),
  .first_pad_osc_run(first_pad_osc_run),
  .oscillator_frequency_select(oscillator_frequency_select), .irq(irq));
`default_nettype wire

//--- testbench/touch_pad_model.sv
`timescale 1ns/1ns
`default_nettype none
module touch_pad_model #(
  parameter int PAD1_HALF = 2,
  parameter int PAD2_HALF = 1,
  parameter int REF_HALF = 5
)
(
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // oscillator run levels
  input wire logic ref_osc_run,
  input wire logic first_pad_osc_run,
  input wire logic second_pad_osc_run,
  // oscillator waveforms
  output logic first_sense_pad,
  output logic second_sense_pad,
  output logic ref_osc_in
);
  // ==========
  // one oscillator per pad plus reference, resting low when stopped
  localparam int HALF [3] = '{PAD1_HALF, PAD2_HALF, REF_HALF};
  logic [2:0] run;
  logic [2:0] wave;
  int cnt [3];
  assign run = {ref_osc_run, second_pad_osc_run, first_pad_osc_run};
  assign {ref_osc_in, second_sense_pad, first_sense_pad} = wave;
  always @(posedge hclk or negedge hresetn)
    for (int i = 0; i < 3; i++)
      if (!hresetn || !run[i])
      begin
        wave[i] <= 1'b0;
        cnt[i] <= 1;
      end
      else if (cnt[i] == HALF[i])
      begin
        wave[i] <= !wave[i];
        cnt[i] <= 1;
      end
      else
        cnt[i] <= cnt[i] + 1;
endmodule
`default_nettype wire

//--- testbench/capacitive_touch_key_counter_tb.sv
`timescale 1ns/1ns
`default_nettype none
module capacitive_touch_key_counter_tb
  import touch_key_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
  logic [31:0] haddr, hwdata, hrdata, v, c, d;
  logic [1:0] htrans, freq;
  logic pad1, pad2, refo, rrun, p1run, p2run;
  logic [9:0] refcap;
  logic [5:0] tune;
  int failures, n_tests, n;
  capacitive_touch_key_counter capacitive_touch_key_counter_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .first_sense_pad(pad1), .second_sense_pad(pad2),
    .ref_osc_in(refo), .ref_osc_run(rrun), .first_pad_osc_run(p1run),
    .second_pad_osc_run(p2run), .oscillator_frequency_select(freq),
    .ref_capacitor(refcap), .pad_osc_tuning(tune), .irq(irq));
  touch_pad_model touch_pad_model_inst (
    .hclk(hclk), .hresetn(hresetn), .ref_osc_run(rrun),
    .first_pad_osc_run(p1run), .second_pad_osc_run(p2run),
    .first_sense_pad(pad1), .second_sense_pad(pad2), .ref_osc_in(refo));
  // ==========
  // checks and bus access
  task automatic chk(input logic [31:0] got, lo, hi);
    n_tests++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, lo);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    v = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] lo, hi);
    bus(1'b0, a, 32'h0);
    chk(v, lo, hi);
  endtask
  task automatic rd16(input logic [7:0] a, output logic [31:0] cnt);
    bus(1'b0, a, 32'h0);
    cnt = v & 32'hff;
    bus(1'b0, a + 8'h04, 32'h0);
    cnt = cnt | (v[7:0] << 8);
  endtask
  task automatic go(input logic [7:0] pre, ma, mb, sel, mask, output int k);
    bus(1'b1, OFS_SLOT_PRELOAD, pre);
    bus(1'b1, OFS_MODULE_CONTROL_A, ma);
    bus(1'b1, OFS_MODULE_CONTROL_B, mb);
    bus(1'b1, OFS_IRQ_MASK, mask);
    bus(1'b1, OFS_SENSE_CONTROL_A, 8'h20 | sel);
    k = 0;
    while (rrun !== 1'b1 && k < 4)
    begin
      @(posedge hclk);
      k++;
    end
    chk(rrun, 1, 1);
    chk(p1run, mb[4] & mb[0], mb[4] & mb[0]);
    chk(p2run, mb[4] & mb[1], mb[4] & mb[1]);
    while (rrun === 1'b1 && k < 90000)
    begin
      @(posedge hclk);
      k++;
    end
    chk(rrun, 0, 0);
    chk(p1run | p2run, 0, 0);
  endtask
  // ==========
  // scenarios
  task automatic t_reset();
    rdc(OFS_SENSE_CONTROL_B, 3, 3);
    chk(freq, 3, 3);
    rdc(OFS_SENSE_CONTROL_A, 0, 0);
    rd16(OFS_CALIB_COUNT_LOW, c);
    chk(c, 0, 0);
    chk(irq, 0, 0);
    $display("reset test done");
  endtask
  task automatic t_regs();
    bus(1'b1, OFS_SENSE_CONTROL_B, 32'hfffffffe);
    rdc(OFS_SENSE_CONTROL_B, 2, 2);
    chk(freq, 2, 2);
    bus(1'b1, OFS_MODULE_CONTROL_B, 32'hff);
    rdc(OFS_MODULE_CONTROL_B, 32'hb3, 32'hb3);
    bus(1'b1, OFS_SENSE_CONTROL_A, 32'h84);
    rdc(OFS_SENSE_CONTROL_A, 0, 0);
    rdc(8'h3c, 0, 0);
    chk(hresp, 0, 0);
    bus(1'b1, OFS_REF_CAPACITOR_LOW, 32'ha5);
    bus(1'b1, OFS_REF_CAPACITOR_HIGH, 32'hfe);
    rdc(OFS_REF_CAPACITOR_HIGH, 2, 2);
    chk(refcap, 10'h2a5, 10'h2a5);
    bus(1'b1, OFS_MODULE_CONTROL_A, 32'h5a);
    rdc(OFS_MODULE_CONTROL_A, 32'h5a, 32'h5a);
    chk(tune, 6'h1a, 6'h1a);
    $display("register test done");
  endtask
  task automatic t_window();
    go(8'hfe, 8'h00, 8'hb1, 8'h00, 8'h01, n);
    chk(n, 254, 262);
    rdc(OFS_SENSE_CONTROL_A, 32'h60, 32'h60);
    chk(irq, 1, 1);
    rd16(OFS_PAD_COUNT_LOW, d);
    chk(d, 62, 66);
    rd16(OFS_CALIB_COUNT_LOW, c);
    chk(c, n - 6, n + 2);
    repeat (20) @(posedge hclk);
    rd16(OFS_CALIB_COUNT_LOW, v);
    chk(v, c, c);
    rd16(OFS_PAD_COUNT_LOW, v);
    chk(v, d, d);
    bus(1'b1, OFS_IRQ_STATUS, 32'h1);
    bus(1'b1, OFS_SENSE_CONTROL_A, 32'h60);
    rdc(OFS_IRQ_STATUS, 0, 0);
    chk(irq, 0, 0);
    bus(1'b1, OFS_SENSE_CONTROL_A, 32'h0);
    rd16(OFS_CALIB_COUNT_LOW, c);
    chk(c, 0, 0);
    rd16(OFS_PAD_COUNT_LOW, c);
    chk(c, 0, 0);
    $display("window test done");
  endtask
  task automatic t_div();
    for (int s = 0; s < 4; s++)
    begin
      go(8'hff, 8'h80, 8'hb3, s[7:0], 8'h00, n);
      chk(n, 126, 134);
      rd16(OFS_PAD_COUNT_LOW, d);
      chk(d, 0, 0);
      rd16(OFS_CALIB_COUNT_LOW, c);
      chk(c, (n >> s) - 3, (n >> s) + 3);
      bus(1'b1, OFS_SENSE_CONTROL_A, 32'h0);
    end
    $display("divider test done");
  endtask
  task automatic t_ovf();
    go(8'h00, 8'h40, 8'h32, 8'h00, 8'h00, n);
    chk(n, 81910, 81940);
    rdc(OFS_IRQ_STATUS, 5, 5);
    chk(irq, 0, 0);
    bus(1'b1, OFS_IRQ_MASK, 32'h4);
    rdc(OFS_SENSE_CONTROL_A, 32'h68, 32'h68);
    chk(irq, 1, 1);
    rd16(OFS_CALIB_COUNT_LOW, c);
    chk(c, n - 65540, n - 65532);
    rd16(OFS_PAD_COUNT_LOW, c);
    chk(c, n / 2 - 3, n / 2 + 3);
    bus(1'b1, OFS_IRQ_STATUS, 32'h7);
    bus(1'b1, OFS_SENSE_CONTROL_A, 32'h0);
    rdc(OFS_SENSE_CONTROL_A, 0, 0);
    chk(irq, 0, 0);
    $display("overflow test done");
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==========
  // clock, reset, sequence, watchdog
  initial
  begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_regs();
    t_window();
    t_div();
    t_ovf();
    give_verdict();
  end
  initial
  begin
    repeat (100000) @(posedge hclk);
    failures++;
    give_verdict();
  end
endmodule
`default_nettype wire
